// >>> verilog/tba_cmd_engine.sv
// Command handler for tag authenticate, block read, value read and block write
`timescale 1ns/1ns
`default_nettype none
`include "tba_map.svh"
module tba_cmd_engine import tba_pkg::*; (
    // Clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // Command bytes from frame transport
    input wire tba_byte_s cmd_in,
    input wire logic cmd_valid,
    output logic cmd_ready,
    // Response bytes to frame transport
    output var tba_byte_s rsp_out,
    output logic rsp_valid,
    input wire logic rsp_ready,
    output logic [7:0] rsp_len,
    // Tag access engine
    output var tba_req_s tag_req,
    output logic tag_req_valid,
    input wire logic tag_done,
    input wire tba_rsp_s tag_rsp,
    input wire logic tag_selected,
    input wire logic tag_is_ul
);
    // ----------------------------------------
    // Decoding helpers
    // ----------------------------------------
    function automatic logic sel_supplied(input logic [7:0] sel);
        sel_supplied = (sel == `TBA_SEL_KEY_A) || (sel == `TBA_SEL_KEY_B);
    endfunction

    function automatic logic sel_legal(input logic [7:0] sel);
        sel_legal = sel_supplied(sel) || (sel == `TBA_SEL_TRANSPORT) ||
                    (sel[7:4] == `TBA_SEL_NV_A_HI) || (sel[7:4] == `TBA_SEL_NV_B_HI);
    endfunction

    // Value block: value, inverted value, value, then address pattern
    function automatic logic value_ok(input logic [127:0] d);
        value_ok = (d[63:32] == ~d[31:0]) && (d[95:64] == d[31:0]) &&
                   (d[111:104] == ~d[103:96]) && (d[119:112] == d[103:96]) &&
                   (d[127:120] == ~d[103:96]);
    endfunction

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef enum {ST_RX, ST_ISSUE, ST_WAIT, ST_BUILD, ST_EMIT} tba_state_e;
    tba_state_e state;
    tba_state_e next_state;

    logic [7:0] cmd;
    logic [7:0] blk;
    logic [7:0] ksel;
    logic [47:0] key;
    logic [127:0] wdata;
    logic [127:0] rdata;
    logic [4:0] idx;
    logic [1:0] page;
    logic verify;
    logic full_rsp;
    logic [7:0] code;
    logic [7:0] rlen;
    logic [1:0] ph;
    logic [7:0] frame_checksum;
    logic auth_ok;
    logic [7:0] auth_blk;
    logic [7:0] mem_q;
    logic [1:0] cnt;
    tba_byte_s slot1;

    logic take;
    logic frame_end;
    logic frame_good;
    logic [7:0] cmd_now;
    logic [7:0] sel_now;
    logic authed;
    logic done_build;
    logic push;
    tba_byte_s push_byte;
    logic pop;
    logic space;
    logic [7:0] build_byte;
    logic [1:0] next_cnt;

    assign take = cmd_valid && cmd_ready;
    assign frame_end = take && cmd_in.last;
    assign cmd_now = (idx == 5'h00) ? cmd_in.data : cmd;
    assign sel_now = (idx == `TBA_IDX_SEL) ? cmd_in.data : ksel;
    assign authed = tag_is_ul || (auth_ok && (auth_blk == blk));
    assign pop = rsp_valid && rsp_ready;
    assign space = (cnt != 2'd2);
    assign done_build = ({3'b000, idx} == rlen);

    // ----------------------------------------
    // Frame completeness check
    // ----------------------------------------
    always_comb begin
        frame_good = 1'b0;
        unique case (cmd_now)
            `TBA_CMD_AUTH: frame_good = sel_supplied(sel_now) ? (idx == `TBA_IDX_KEY_END)
                                                               : (idx == `TBA_IDX_SEL);
            `TBA_CMD_READ: frame_good = (idx == 5'h01);
            `TBA_CMD_VREAD: frame_good = (idx == 5'h01);
            `TBA_CMD_WRITE: frame_good = (idx == `TBA_IDX_DATA_END);
            default: frame_good = 1'b0;
        endcase
    end

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    always_comb begin
        next_state = state;
        unique case (state)
            ST_RX: begin
                if (frame_end && frame_good) begin
                    next_state = ST_ISSUE;
                end
            end
            ST_ISSUE: begin
                if (cmd == `TBA_CMD_AUTH) begin
                    next_state = sel_legal(ksel) ? ST_WAIT : ST_BUILD;
                end else begin
                    next_state = authed ? ST_WAIT : ST_BUILD;
                end
            end
            ST_WAIT: begin
                if (tag_done) begin
                    if (tag_rsp.status == TBA_TAG_OK &&
                        ((cmd == `TBA_CMD_READ && tag_is_ul && page != `TBA_UL_LAST_PAGE) ||
                         (cmd == `TBA_CMD_WRITE && !verify))) begin
                        next_state = ST_ISSUE;
                    end else begin
                        next_state = ST_BUILD;
                    end
                end
            end
            ST_BUILD: begin
                if (done_build) begin
                    next_state = ST_EMIT;
                end
            end
            ST_EMIT: begin
                if (ph == 2'd2 && space) begin
                    next_state = ST_RX;
                end
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            state <= ST_RX;
            cmd_ready <= 1'b0;
        end else begin
            state <= next_state;
            cmd_ready <= (next_state == ST_RX);
        end
    end

    // ----------------------------------------
    // Command capture
    // ----------------------------------------
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            cmd <= 8'h00;
            blk <= 8'h00;
            ksel <= 8'h00;
            key <= 48'h0000_0000_0000;
            wdata <= 128'h0;
        end else if (take) begin
            unique case (idx)
                5'h00: cmd <= cmd_in.data;
                5'h01: blk <= cmd_in.data;
                default: begin
                    if (cmd == `TBA_CMD_AUTH && idx == `TBA_IDX_SEL) begin
                        ksel <= cmd_in.data;
                    end else if (cmd == `TBA_CMD_AUTH) begin
                        key <= {key[39:0], cmd_in.data};
                    end
                    if (cmd == `TBA_CMD_WRITE && idx <= `TBA_IDX_DATA_END) begin
                        wdata[(idx - `TBA_IDX_DATA) * 8 +: 8] <= cmd_in.data;
                    end
                end
            endcase
        end
    end

    // Byte index, shared by receive, build and emit
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            idx <= 5'h00;
        end else if (state == ST_RX) begin
            if (frame_end) begin
                idx <= 5'h00;
            end else if (take && idx != 5'h1f) begin
                idx <= idx + 5'h01;
            end
        end else if (state == ST_BUILD) begin
            idx <= done_build ? 5'h00 : idx + 5'h01;
        end else if (state == ST_EMIT && ph == 2'd1 && space) begin
            // Back to zero after the last byte so the next frame starts at its code
            idx <= done_build ? 5'h00 : idx + 5'h01;
        end
    end

    // ----------------------------------------
    // Tag engine requests
    // ----------------------------------------
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            tag_req <= '0;
            tag_req_valid <= 1'b0;
        end else if (state == ST_ISSUE && next_state == ST_WAIT) begin
            tag_req_valid <= 1'b1;
            tag_req.block <= blk + {6'h00, page};
            tag_req.data <= wdata;
            tag_req.key_b <= (ksel == `TBA_SEL_KEY_B) || (ksel[7:4] == `TBA_SEL_NV_B_HI);
            tag_req.key_sector <= ksel[3:0];
            if (cmd == `TBA_CMD_AUTH) begin
                tag_req.op <= TBA_OP_AUTH;
            end else if (cmd == `TBA_CMD_WRITE && !verify) begin
                tag_req.op <= TBA_OP_WRITE;
            end else begin
                tag_req.op <= TBA_OP_READ;
            end
            if (sel_supplied(ksel)) begin
                tag_req.key_src <= TBA_KEY_SUPPLIED;
                tag_req.key <= key;
            end else if (ksel == `TBA_SEL_TRANSPORT) begin
                tag_req.key_src <= TBA_KEY_TRANSPORT;
                tag_req.key <= `TBA_TRANSPORT_KEY;
            end else begin
                tag_req.key_src <= TBA_KEY_STORED;
                tag_req.key <= 48'h0000_0000_0000;
            end
        end else begin
            tag_req_valid <= 1'b0;
        end
    end

    // ----------------------------------------
    // Result evaluation
    // ----------------------------------------
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            page <= 2'h0;
            verify <= 1'b0;
            full_rsp <= 1'b0;
            code <= 8'h00;
            rdata <= 128'h0;
        end else if (state == ST_RX) begin
            page <= 2'h0;
            verify <= 1'b0;
            full_rsp <= 1'b0;
        end else if (state == ST_ISSUE && next_state == ST_BUILD) begin
            code <= (cmd == `TBA_CMD_AUTH) ? `TBA_ERR_NO_TAG : `TBA_ERR_FAIL;
        end else if (state == ST_WAIT && tag_done) begin
            unique case (cmd)
                `TBA_CMD_AUTH: begin
                    code <= (tag_rsp.status == TBA_TAG_OK) ? `TBA_ST_LOGIN_OK : `TBA_ERR_NO_TAG;
                end
                `TBA_CMD_READ: begin
                    if (tag_rsp.status != TBA_TAG_OK) begin
                        code <= (tag_rsp.status == TBA_TAG_NONE) ? `TBA_ERR_NO_TAG : `TBA_ERR_FAIL;
                    end else if (tag_is_ul) begin
                        rdata[page * 32 +: 32] <= tag_rsp.data[31:0];
                        page <= page + 2'h1;
                        full_rsp <= (page == `TBA_UL_LAST_PAGE);
                    end else begin
                        rdata <= tag_rsp.data;
                        full_rsp <= 1'b1;
                    end
                end
                `TBA_CMD_VREAD: begin
                    if (tag_rsp.status != TBA_TAG_OK) begin
                        code <= (tag_rsp.status == TBA_TAG_NONE) ? `TBA_ERR_NO_TAG : `TBA_ERR_FAIL;
                    end else if (!value_ok(tag_rsp.data)) begin
                        code <= `TBA_ERR_VALUE;
                    end else begin
                        rdata <= tag_rsp.data;
                        full_rsp <= 1'b1;
                    end
                end
                default: begin
                    if (!verify) begin
                        verify <= (tag_rsp.status == TBA_TAG_OK);
                        code <= (tag_rsp.status == TBA_TAG_NONE) ? `TBA_ERR_NO_TAG : `TBA_ERR_FAIL;
                    end else if (tag_rsp.status != TBA_TAG_OK) begin
                        code <= `TBA_ERR_NO_READBACK;
                    end else if (tag_rsp.data != wdata) begin
                        code <= `TBA_ERR_MISMATCH;
                    end else begin
                        rdata <= tag_rsp.data;
                        full_rsp <= 1'b1;
                    end
                end
            endcase
        end
    end

    // Login state follows the last authenticate and any new selection
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            auth_ok <= 1'b0;
            auth_blk <= 8'h00;
        end else if (tag_selected) begin
            auth_ok <= 1'b0;
        end else if (state == ST_WAIT && tag_done && cmd == `TBA_CMD_AUTH) begin
            auth_ok <= (tag_rsp.status == TBA_TAG_OK);
            auth_blk <= blk;
        end else if (state == ST_ISSUE && cmd == `TBA_CMD_AUTH && !sel_legal(ksel)) begin
            auth_ok <= 1'b0;
        end
    end

    // ----------------------------------------
    // Response build into frame memory
    // ----------------------------------------
    always_comb begin
        if (!full_rsp) begin
            rlen = `TBA_LEN_ERROR;
        end else if (cmd == `TBA_CMD_VREAD) begin
            rlen = `TBA_LEN_VALUE;
        end else begin
            rlen = `TBA_LEN_BLOCK;
        end
    end

    always_comb begin
        unique case (idx)
            5'h00: build_byte = rlen;
            5'h01: build_byte = cmd;
            5'h02: build_byte = full_rsp ? blk : code;
            default: build_byte = rdata[(idx - `TBA_IDX_RSP_DATA) * 8 +: 8];
        endcase
    end

    tba_rsp_mem u_mem (
        .core_clk(core_clk),
        .we(state == ST_BUILD),
        .waddr(idx),
        .wdata(build_byte),
        .raddr(idx),
        .rdata(mem_q)
    );

    // ----------------------------------------
    // Emit with running checksum
    // ----------------------------------------
    // Phase 0 addresses memory, 1 pushes the byte, 2 pushes the checksum
    always_comb begin
        push = 1'b0;
        push_byte = '0;
        if (state == ST_EMIT && space) begin
            if (ph == 2'd1) begin
                push = 1'b1;
                push_byte.data = mem_q;
            end else if (ph == 2'd2) begin
                push = 1'b1;
                push_byte.data = frame_checksum;
                push_byte.last = 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            ph <= 2'd0;
            frame_checksum <= 8'h00;
        end else if (state != ST_EMIT) begin
            ph <= 2'd0;
            frame_checksum <= 8'h00;
        end else if (ph == 2'd0) begin
            ph <= 2'd1;
        end else if (ph == 2'd1 && space) begin
            frame_checksum <= frame_checksum + mem_q;
            ph <= done_build ? 2'd2 : 2'd0;
        end
    end

    // Length is zero from command acceptance until its answer exists
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            rsp_len <= 8'h00;
        end else if (take) begin
            rsp_len <= 8'h00;
        end else if (state == ST_BUILD && done_build) begin
            rsp_len <= rlen;
        end
    end

    // ----------------------------------------
    // Two-entry output buffer
    // ----------------------------------------
    // Head slot drives the port, so a stalled receiver loses nothing
    assign next_cnt = cnt + {1'b0, push} - {1'b0, pop};

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            cnt <= 2'd0;
            rsp_valid <= 1'b0;
            rsp_out <= '0;
            slot1 <= '0;
        end else begin
            cnt <= next_cnt;
            rsp_valid <= (next_cnt != 2'd0);
            if (pop && cnt == 2'd2) begin
                rsp_out <= slot1;
            end
            if (push) begin
                if (cnt == 2'd0 || (cnt == 2'd1 && pop)) begin
                    rsp_out <= push_byte;
                end else begin
                    slot1 <= push_byte;
                end
            end
        end
    end
endmodule
`default_nettype wire

// >>> verilog/tba_map.svh
// Constants of the tag block access command handler
`ifndef TBA_MAP_SVH
`define TBA_MAP_SVH

// ----------------------------------------
// Command codes
// ----------------------------------------
`define TBA_CMD_AUTH 8'h85
`define TBA_CMD_READ 8'h86
`define TBA_CMD_VREAD 8'h87
`define TBA_CMD_WRITE 8'h89

// ----------------------------------------
// Key selectors
// ----------------------------------------
`define TBA_SEL_KEY_A 8'haa
`define TBA_SEL_KEY_B 8'hbb
`define TBA_SEL_TRANSPORT 8'hff
`define TBA_SEL_NV_A_HI 4'h1
`define TBA_SEL_NV_B_HI 4'h2
`define TBA_TRANSPORT_KEY 48'hffff_ffff_ffff

// ----------------------------------------
// Status and error bytes
// ----------------------------------------
`define TBA_ST_LOGIN_OK 8'h4c
`define TBA_ERR_NO_TAG 8'h4e
`define TBA_ERR_FAIL 8'h46
`define TBA_ERR_VALUE 8'h49
`define TBA_ERR_MISMATCH 8'h55
`define TBA_ERR_NO_READBACK 8'h58

// ----------------------------------------
// Frame lengths and positions
// ----------------------------------------
`define TBA_LEN_BLOCK 8'h12
`define TBA_LEN_VALUE 8'h06
`define TBA_LEN_ERROR 8'h02
`define TBA_IDX_SEL 5'h02
`define TBA_IDX_KEY_END 5'h08
`define TBA_IDX_DATA 5'h02
`define TBA_IDX_DATA_END 5'h11
`define TBA_IDX_RSP_DATA 5'h03
`define TBA_UL_LAST_PAGE 2'h3
`define TBA_MEM_DEPTH 32

`endif

// >>> verilog/tba_pkg.sv
// Types of the tag block access command handler
package tba_pkg;

    typedef enum logic [1:0] {TBA_OP_AUTH, TBA_OP_READ, TBA_OP_WRITE} tba_op_e;
    typedef enum logic [1:0] {TBA_KEY_SUPPLIED, TBA_KEY_TRANSPORT, TBA_KEY_STORED} tba_keysrc_e;
    typedef enum logic [1:0] {TBA_TAG_OK, TBA_TAG_NONE, TBA_TAG_FAIL} tba_tstat_e;

    typedef struct packed {
        logic [7:0] data;
        logic last;
    } tba_byte_s;

    typedef struct packed {
        tba_op_e op;
        logic [7:0] block;
        logic key_b;
        tba_keysrc_e key_src;
        logic [3:0] key_sector;
        logic [47:0] key;
        logic [127:0] data;
    } tba_req_s;

    typedef struct packed {
        tba_tstat_e status;
        logic [127:0] data;
    } tba_rsp_s;

endpackage

// >>> verilog/tba_rsp_mem.sv
// Response frame memory with registered read data
`timescale 1ns/1ns
`default_nettype none
`include "tba_map.svh"
module tba_rsp_mem (
    // Clock
    input wire logic core_clk,
    // Write port
    input wire logic we,
    input wire logic [4:0] waddr,
    input wire logic [7:0] wdata,
    // Read port
    input wire logic [4:0] raddr,
    output logic [7:0] rdata
);
    logic [7:0] mem [`TBA_MEM_DEPTH];

    always_ff @(posedge core_clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge core_clk) begin
        rdata <= mem[raddr];
    end
endmodule
`default_nettype wire

// >>> verif/tba_cmd_engine_properties.sv
// Port checks of the tag block access command handler
`timescale 1ns/1ns
`default_nettype none
`include "tba_map.svh"
module tba_cmd_engine_properties import tba_pkg::*; (
    // Clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // Streams
    input wire logic cmd_ready,
    input wire tba_byte_s rsp_out,
    input wire logic rsp_valid,
    input wire logic rsp_ready,
    input wire logic [7:0] rsp_len,
    // Tag side
    input wire tba_req_s tag_req,
    input wire logic tag_req_valid
);
    logic first;
    logic [7:0] sum;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    // Frame position and running sum of bytes already taken
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            first <= 1'b1;
            sum <= 8'h00;
        end else if (rsp_valid && rsp_ready) begin
            first <= rsp_out.last;
            sum <= rsp_out.last ? 8'h00 : sum + rsp_out.data;
        end
    end
    a_rsp_hold_stall: assert property (rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_out))
        else $error("response byte changed under stall");
    a_req_one_pulse: assert property (tag_req_valid |=> !tag_req_valid)
        else $error("tag request longer than one cycle");
    a_busy_no_cmd: assert property (tag_req_valid |-> !cmd_ready)
        else $error("command accepted while executing");
    a_len_zero_busy: assert property (tag_req_valid |-> rsp_len == 8'h00)
        else $error("length not zero while executing");
    a_len_first_byte: assert property (rsp_valid && first |-> rsp_out.data == rsp_len && !rsp_out.last)
        else $error("first byte is not the length");
    a_len_known: assert property (rsp_valid && first |->
        rsp_len inside {`TBA_LEN_BLOCK, `TBA_LEN_VALUE, `TBA_LEN_ERROR})
        else $error("unexpected response length");
    a_frame_checksum_last: assert property (rsp_valid && rsp_out.last |-> rsp_out.data == sum)
        else $error("checksum byte wrong");
    a_transport_key: assert property (tag_req_valid && tag_req.key_src == TBA_KEY_TRANSPORT |->
        tag_req.key == `TBA_TRANSPORT_KEY && !tag_req.key_b)
        else $error("transport login without all-ones key A");
    c_block_frame: cover property (rsp_valid && first && rsp_len == `TBA_LEN_BLOCK);
    c_write_req: cover property (tag_req_valid && tag_req.op == TBA_OP_WRITE);
    c_stall: cover property (rsp_valid && !rsp_ready ##1 rsp_valid && rsp_ready);
endmodule
bind tba_cmd_engine tba_cmd_engine_properties u_props (.core_clk, .nrst, .cmd_ready, .rsp_out, .rsp_valid,
    .rsp_ready, .rsp_len, .tag_req, .tag_req_valid);
`default_nettype wire

// >>> verif/tba_tag_model.sv
// Behavioural tag access engine answering block requests
`timescale 1ns/1ns
`default_nettype none
module tba_tag_model import tba_pkg::*; (
    // Clock
    input wire logic core_clk,
    // Requests and answers
    input wire tba_req_s tag_req,
    input wire logic tag_req_valid,
    output var logic tag_done,
    output var tba_rsp_s tag_rsp,
    // Scenario controls
    input wire logic [3:0] lat,
    input wire tba_tstat_e au_st,
    input wire tba_tstat_e wr_st,
    input wire tba_tstat_e rd_st,
    input wire logic flip
);
    logic [127:0] mem [256];
    int cnt = -1;
    initial begin
        for (int i = 0; i < 256; i++) mem[i] = {16{8'(i)}};
        tag_done = 1'b0;
        tag_rsp = '0;
    end
    always @(posedge core_clk) begin
        tag_done <= 1'b0;
        // Data is only valid with done, so it toggles otherwise
        tag_rsp.data <= ~tag_rsp.data;
        if (tag_req_valid)
            cnt <= lat;
        else if (cnt > 0)
            cnt <= cnt - 1;
        else if (cnt == 0) begin
            cnt <= -1;
            tag_done <= 1'b1;
            case (tag_req.op)
                TBA_OP_AUTH: tag_rsp.status <= au_st;
                TBA_OP_WRITE: begin
                    tag_rsp.status <= wr_st;
                    if (wr_st == TBA_TAG_OK) mem[tag_req.block] <= tag_req.data;
                end
                default: begin
                    tag_rsp.status <= rd_st;
                    // Flip stands for a read back that differs from the stored block in bit 0
                    tag_rsp.data <= mem[tag_req.block] ^ 128'(flip);
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// >>> verif/tba_cmd_engine_tb_top.sv
// Self-checking bench of the tag block access command handler
`timescale 1ns/1ns
`default_nettype none
`include "tba_map.svh"
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin failures++; \
    $display("CHECK FAILED %s expected %h seen %h", n, e, g); end end
module tba_cmd_engine_tb_top import tba_pkg::*;;
    logic core_clk = 0, nrst = 0, cmd_valid = 0, rsp_ready = 0, tag_selected = 0, tag_is_ul = 0, flip = 0;
    logic cmd_ready, rsp_valid, tag_req_valid, tag_done;
    logic [3:0] lat = 0;
    logic [7:0] rsp_len;
    logic [31:0] seed = 32'h0000a88d;
    tba_byte_s cmd_in = '0, rsp_out;
    tba_req_s tag_req, last_req;
    tba_rsp_s tag_rsp;
    tba_tstat_e au_st = TBA_TAG_OK, wr_st = TBA_TAG_OK, rd_st = TBA_TAG_OK;
    tba_tstat_e ws[4] = '{TBA_TAG_NONE, TBA_TAG_FAIL, TBA_TAG_OK, TBA_TAG_OK};
    tba_tstat_e rs[4] = '{TBA_TAG_OK, TBA_TAG_OK, TBA_TAG_FAIL, TBA_TAG_OK};
    logic [7:0] er[4] = '{`TBA_ERR_NO_TAG, `TBA_ERR_FAIL, `TBA_ERR_NO_READBACK, `TBA_ERR_MISMATCH};
    logic [7:0] sel[6] = '{8'haa, 8'hbb, 8'hff, 8'h13, 8'h2a, 8'h30};
    logic [7:0] q[$], d[$], p[$];
    int failures = 0, total_checks = 0;
    tba_cmd_engine dut (.core_clk, .nrst, .cmd_in, .cmd_valid, .cmd_ready, .rsp_out, .rsp_valid, .rsp_ready,
        .rsp_len, .tag_req, .tag_req_valid, .tag_done, .tag_rsp, .tag_selected, .tag_is_ul);
    tba_tag_model far (.core_clk, .tag_req, .tag_req_valid, .tag_done, .tag_rsp, .lat, .au_st, .wr_st, .rd_st,
        .flip);
    initial forever #10 core_clk = ~core_clk;
    always @(posedge core_clk) if (tag_req_valid) last_req <= tag_req;
    function automatic logic [7:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction
    task automatic final_report();
        $display("Checks %0d, mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // ----------------------------------------
    // Send q as one frame, expect payload x
    // ----------------------------------------
    task automatic run(input logic [7:0] x[$]);
        logic [7:0] e[$];
        logic [7:0] s;
        int n;
        e = {8'(x.size()), x};
        s = 8'h00;
        foreach (e[i]) s += e[i];
        e.push_back(s);
        n = 0;
        lat = 4'(rnd() & 8'h07);
        foreach (q[i]) begin
            @(negedge core_clk);
            cmd_valid = 1'b1;
            cmd_in = '{data: q[i], last: i == q.size() - 1};
            while (cmd_ready !== 1'b1) @(negedge core_clk);
        end
        @(negedge core_clk);
        cmd_valid = 1'b0;
        // Random stalls exercise the response buffer
        for (int k = 0; k < 4000 && n < e.size(); k++) begin
            @(negedge core_clk);
            rsp_ready = rnd() > 8'h50;
            if (rsp_valid && rsp_ready) begin
                `CHK("rsp byte", e[n], rsp_out.data)
                `CHK("rsp last", n == e.size() - 1, rsp_out.last)
                n++;
            end
        end
        `CHK("rsp count", e.size(), n)
        `CHK("rsp len", e[0], rsp_len)
    endtask
    task automatic auth(input logic [7:0] b);
        q = {`TBA_CMD_AUTH, b, `TBA_SEL_TRANSPORT};
        run({`TBA_CMD_AUTH, `TBA_ST_LOGIN_OK});
    endtask
    initial begin
        logic kb;
        tba_keysrc_e ks;
        logic [47:0] kv;
        repeat (20) @(negedge core_clk);
        nrst = 1'b1;
        q = {`TBA_CMD_READ, 8'h05};
        run({`TBA_CMD_READ, `TBA_ERR_FAIL});
        foreach (sel[i]) begin
            q = {`TBA_CMD_AUTH, 8'h09, sel[i]};
            kv = '0;
            kb = sel[i] == `TBA_SEL_KEY_B || sel[i][7:4] == `TBA_SEL_NV_B_HI;
            ks = sel[i] inside {`TBA_SEL_KEY_A, `TBA_SEL_KEY_B} ? TBA_KEY_SUPPLIED
                : sel[i] == `TBA_SEL_TRANSPORT ? TBA_KEY_TRANSPORT : TBA_KEY_STORED;
            for (int j = 0; j < 6 && ks == TBA_KEY_SUPPLIED; j++) begin
                q.push_back(rnd());
                kv = {kv[39:0], q[$]};
            end
            run({`TBA_CMD_AUTH, i == 5 ? `TBA_ERR_NO_TAG : `TBA_ST_LOGIN_OK});
            if (i < 5) begin
                `CHK("key type", kb, last_req.key_b)
                `CHK("key source", ks, last_req.key_src)
                if (ks == TBA_KEY_SUPPLIED) `CHK("key", kv, last_req.key)
                if (ks == TBA_KEY_STORED) `CHK("key sector", sel[i][3:0], last_req.key_sector)
            end
        end
        au_st = TBA_TAG_NONE;
        q = {`TBA_CMD_AUTH, 8'h08, `TBA_SEL_TRANSPORT};
        run({`TBA_CMD_AUTH, `TBA_ERR_NO_TAG});
        au_st = TBA_TAG_OK;
        q = {`TBA_CMD_READ, 8'h08};
        run({`TBA_CMD_READ, `TBA_ERR_FAIL});
        auth(8'h08);
        for (int j = 0; j < 4; j++) d.push_back(rnd());
        d = {d, ~d[0], ~d[1], ~d[2], ~d[3], d[0:3], 8'h08, 8'hf7, 8'h08, 8'hf7};
        q = {`TBA_CMD_WRITE, 8'h08, d};
        run({`TBA_CMD_WRITE, 8'h08, d});
        q = {`TBA_CMD_READ, 8'h08};
        run({`TBA_CMD_READ, 8'h08, d});
        q = {`TBA_CMD_VREAD, 8'h08};
        run({`TBA_CMD_VREAD, 8'h08, d[0:3]});
        d[4] = d[0];
        q = {`TBA_CMD_WRITE, 8'h08, d};
        run({`TBA_CMD_WRITE, 8'h08, d});
        q = {`TBA_CMD_VREAD, 8'h08};
        run({`TBA_CMD_VREAD, `TBA_ERR_VALUE});
        rd_st = TBA_TAG_NONE;
        q = {`TBA_CMD_READ, 8'h08};
        run({`TBA_CMD_READ, `TBA_ERR_NO_TAG});
        q = {`TBA_CMD_VREAD, 8'h08};
        run({`TBA_CMD_VREAD, `TBA_ERR_NO_TAG});
        rd_st = TBA_TAG_FAIL;
        run({`TBA_CMD_VREAD, `TBA_ERR_FAIL});
        for (int c = 0; c < 4; c++) begin
            auth(8'h08);
            wr_st = ws[c];
            rd_st = rs[c];
            flip = c == 3;
            q = {`TBA_CMD_WRITE, 8'h08, d};
            run({`TBA_CMD_WRITE, er[c]});
        end
        flip = 1'b0;
        tag_is_ul = 1'b1;
        p = {`TBA_CMD_READ, 8'h04};
        for (int j = 0; j < 16; j++) p.push_back(8'(4 + j / 4));
        q = p[0:1];
        run(p);
        tag_is_ul = 1'b0;
        auth(8'h08);
        @(negedge core_clk);
        tag_selected = 1'b1;
        @(negedge core_clk);
        tag_selected = 1'b0;
        q = {`TBA_CMD_READ, 8'h08};
        run({`TBA_CMD_READ, `TBA_ERR_FAIL});
        final_report();
    end
    initial begin
        #400000;
        failures++;
        final_report();
    end
endmodule
`default_nettype wire
